// *** design/spihc_defines.svh ***
// Constants for the SPI host/client serial port: offsets, fields, modes.
// Assumes a single 250 MHz system clock and a plain register port.
`ifndef SPIHC_DEFINES_SVH
`define SPIHC_DEFINES_SVH

`define SPIHC_ADDR_STATUS 3'h0
`define SPIHC_ADDR_CTRL1 3'h1
`define SPIHC_ADDR_CTRL3 3'h2
`define SPIHC_ADDR_DATA 3'h3
`define SPIHC_ADDR_RELOAD 3'h4
`define SPIHC_ADDR_FLAG 3'h5

`define SPIHC_BIT_SMP 7
`define SPIHC_BIT_CKE 6
`define SPIHC_BIT_BF 0
`define SPIHC_BIT_WRITE_COLLISION_FLAG 7
`define SPIHC_BIT_OVF 6
`define SPIHC_BIT_EN 5
`define SPIHC_BIT_CKP 4
`define SPIHC_BIT_BUFFER_OVERWRITE_ENABLE 4
`define SPIHC_BIT_IF 0

`define SPIHC_RST_CTRL 1'b0
`define SPIHC_RST_MODE 4'h0
`define SPIHC_RST_BYTE 8'h00

`define SPIHC_MODE_DIV4 4'h0
`define SPIHC_MODE_DIV16 4'h1
`define SPIHC_MODE_DIV64 4'h2
`define SPIHC_MODE_TIMER 4'h3
`define SPIHC_MODE_CLI_SS 4'h4
`define SPIHC_MODE_CLI 4'h5
`define SPIHC_MODE_RELOAD 4'hA

`define SPIHC_HALF_DIV4 10'h002
`define SPIHC_HALF_DIV16 10'h008
`define SPIHC_HALF_DIV64 10'h020
`define SPIHC_HALF_BASE 10'h002
`define SPIHC_LAST_BIT 4'h7
`define SPIHC_LAST_STEP 5'h10

`endif

// *** design/spihc_pkg.sv ***
// Types for the SPI host/client serial port.
// Assumes the defines header is compiled alongside.
package spihc_pkg;

   typedef enum logic {SPIHC_IDLE, SPIHC_SHIFT} spihc_host_type;

   typedef struct packed {
      logic sckS1;
      logic sckS2;
      logic sckPrev;
      logic sdiS1;
      logic sdiS2;
      logic ssS1;
      logic ssS2;
      logic enable;
      logic cpol;
      logic cke;
      logic sample_phase;
      logic buffer_overwrite_enable;
      logic [3:0] mode;
      logic write_collision_flag;
      logic ovf;
      logic bf;
      logic intFlag;
      logic [7:0] dataBuf;
      logic [7:0] reload;
      logic [7:0] shreg;
      logic outBit;
      logic [3:0] bitCnt;
      logic [4:0] step;
      logic [9:0] divCnt;
      spihc_host_type hostState;
      logic sckLvl;
      logic sckOe;
      logic sdoOe;
      logic [7:0] rdData;
      logic sampleDue;
   } spihc_state_type;

endpackage

// *** design/spihc_port.sv ***
// SPI host/client serial port with register port, byte buffer and flags.
// Assumes pins are synchronised here and the period timer is on ref_clk.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/10ps
`include "spihc_defines.svh"

module spihc_port
   import spihc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   input wire logic sleepReq,
   input wire logic periodMatch,
   input wire logic sckIn,
   output logic sckOut,
   output logic sckOe,
   input wire logic sdiIn,
   output logic sdoOut,
   output logic sdoOe,
   input wire logic ssIn_b,
   output logic portInterruptFlag,
   output logic bufferFullFlag
);

   spihc_state_type s;
   spihc_state_type next_s;
   logic hostMode;
   logic clientMode;
   logic ssCtl;
   logic busy;
   logic tick;
   logic leading;
   logic sampleEdge;
   logic changeEdge;
   logic done;
   logic ssActive;
   logic [9:0] half;
   logic [7:0] sh;

   function automatic logic spihc_is_host(input logic [3:0] m);
      spihc_is_host = (m == `SPIHC_MODE_DIV4) || (m == `SPIHC_MODE_DIV16) ||
         (m == `SPIHC_MODE_DIV64) || (m == `SPIHC_MODE_TIMER) ||
         (m == `SPIHC_MODE_RELOAD);
   endfunction

   function automatic logic spihc_is_client(input logic [3:0] m);
      spihc_is_client = (m == `SPIHC_MODE_CLI_SS) || (m == `SPIHC_MODE_CLI);
   endfunction

   function automatic logic [9:0] spihc_half(input logic [3:0] m,
                                             input logic [7:0] r);
      case (m)
         `SPIHC_MODE_DIV4: spihc_half = `SPIHC_HALF_DIV4;
         `SPIHC_MODE_DIV16: spihc_half = `SPIHC_HALF_DIV16;
         `SPIHC_MODE_DIV64: spihc_half = `SPIHC_HALF_DIV64;
         `SPIHC_MODE_RELOAD: spihc_half = {1'b0, r, 1'b0} + `SPIHC_HALF_BASE;
         default: spihc_half = `SPIHC_HALF_DIV4;
      endcase
   endfunction

   always_comb begin
      next_s = s;
      hostMode = s.enable && spihc_is_host(s.mode);
      clientMode = s.enable && spihc_is_client(s.mode);
      ssCtl = s.mode == `SPIHC_MODE_CLI_SS;
      busy = (s.hostState == SPIHC_SHIFT) || (clientMode && s.bitCnt != 4'h0);
      half = spihc_half(s.mode, s.reload);
      tick = 1'b0;
      leading = 1'b0;
      sampleEdge = 1'b0;
      changeEdge = 1'b0;
      done = 1'b0;
      ssActive = 1'b0;
      sh = s.shreg;

      // Pin synchronisers
      next_s.sckS1 = sckIn;
      next_s.sckS2 = s.sckS1;
      next_s.sckPrev = s.sckS2;
      next_s.sdiS1 = sdiIn;
      next_s.sdiS2 = s.sdiS1;
      next_s.ssS1 = ssIn_b;
      next_s.ssS2 = s.ssS1;

      // Register reads; the shift register has no address
      next_s.rdData = 8'h00;
      if (regRd) begin
         if (regAddr == `SPIHC_ADDR_STATUS) begin
            next_s.rdData[`SPIHC_BIT_SMP] = s.sample_phase;
            next_s.rdData[`SPIHC_BIT_CKE] = s.cke;
            next_s.rdData[`SPIHC_BIT_BF] = s.bf;
         end else if (regAddr == `SPIHC_ADDR_CTRL1) begin
            next_s.rdData[`SPIHC_BIT_WRITE_COLLISION_FLAG] = s.write_collision_flag;
            next_s.rdData[`SPIHC_BIT_OVF] = s.ovf;
            next_s.rdData[`SPIHC_BIT_EN] = s.enable;
            next_s.rdData[`SPIHC_BIT_CKP] = s.cpol;
            next_s.rdData[3:0] = s.mode;
         end else if (regAddr == `SPIHC_ADDR_CTRL3) begin
            next_s.rdData[`SPIHC_BIT_BUFFER_OVERWRITE_ENABLE] = s.buffer_overwrite_enable;
         end else if (regAddr == `SPIHC_ADDR_DATA) begin
            next_s.rdData = s.dataBuf;
            next_s.bf = 1'b0;
         end else if (regAddr == `SPIHC_ADDR_RELOAD) begin
            next_s.rdData = s.reload;
         end else if (regAddr == `SPIHC_ADDR_FLAG) begin
            next_s.rdData[`SPIHC_BIT_IF] = s.intFlag;
         end
      end

      // Register writes; flags clear by writing zero, never set by software
      if (regWr) begin
         if (regAddr == `SPIHC_ADDR_STATUS) begin
            next_s.sample_phase = regWdata[`SPIHC_BIT_SMP];
            next_s.cke = regWdata[`SPIHC_BIT_CKE];
         end else if (regAddr == `SPIHC_ADDR_CTRL1) begin
            if (!regWdata[`SPIHC_BIT_WRITE_COLLISION_FLAG]) begin
               next_s.write_collision_flag = 1'b0;
            end
            if (!regWdata[`SPIHC_BIT_OVF]) begin
               next_s.ovf = 1'b0;
            end
            next_s.enable = regWdata[`SPIHC_BIT_EN];
            next_s.cpol = regWdata[`SPIHC_BIT_CKP];
            next_s.mode = regWdata[3:0];
         end else if (regAddr == `SPIHC_ADDR_CTRL3) begin
            next_s.buffer_overwrite_enable = regWdata[`SPIHC_BIT_BUFFER_OVERWRITE_ENABLE];
         end else if (regAddr == `SPIHC_ADDR_RELOAD) begin
            next_s.reload = regWdata;
         end else if (regAddr == `SPIHC_ADDR_FLAG) begin
            if (!regWdata[`SPIHC_BIT_IF]) begin
               next_s.intFlag = 1'b0;
            end
         end else if (regAddr == `SPIHC_ADDR_DATA) begin
            if (busy || s.write_collision_flag) begin
               next_s.write_collision_flag = 1'b1;
            end else begin
               next_s.dataBuf = regWdata;
               next_s.shreg = regWdata;
               sh = regWdata;
               if (s.cke) begin
                  next_s.outBit = regWdata[7];
               end
               if (hostMode) begin
                  next_s.hostState = SPIHC_SHIFT;
                  next_s.step = 5'h00;
                  next_s.divCnt = 10'h000;
               end
            end
         end
      end

      // Shift engine
      if (!s.enable) begin
         next_s.bitCnt = 4'h0;
         next_s.hostState = SPIHC_IDLE;
         next_s.step = 5'h00;
         next_s.sckLvl = s.cpol;
         next_s.sckOe = 1'b0;
         next_s.sdoOe = 1'b0;
         next_s.sampleDue = 1'b0;
      end else if (hostMode) begin
         next_s.sckOe = 1'b1;
         next_s.sdoOe = 1'b1;
         // Capture one cycle after the sample edge: the input synchroniser
         // lags the far side's change by two cycles at the fastest rate
         next_s.sampleDue = 1'b0;
         if (s.sampleDue) begin
            sh = {s.shreg[6:0], s.sdiS2};
            next_s.shreg = sh;
         end
         if (s.hostState == SPIHC_IDLE) begin
            next_s.sckLvl = s.cpol;
         end else if (!sleepReq) begin
            if (s.mode == `SPIHC_MODE_TIMER) begin
               tick = periodMatch;
            end else begin
               tick = s.divCnt == half - 10'h001;
               next_s.divCnt = tick ? 10'h000 : s.divCnt + 10'h001;
            end
            if (tick && s.step != `SPIHC_LAST_STEP) begin
               next_s.sckLvl = ~s.sckLvl;
               leading = !s.step[0];
               changeEdge = s.cke ? !leading : leading;
               if (s.sample_phase) begin
                  sampleEdge = s.cke ? !leading : (leading && s.step != 5'h00);
               end else begin
                  sampleEdge = s.cke ? leading : !leading;
               end
               next_s.sampleDue = sampleEdge;
               next_s.shreg = sh;
               if (changeEdge) begin
                  next_s.outBit = sh[7];
               end
               next_s.step = s.step + 5'h01;
            end else if (tick) begin
               // Late sample for the last bit lands after the final edge
               if (s.sample_phase && !s.cke) begin
                  sh = {s.shreg[6:0], s.sdiS2};
               end
               next_s.shreg = sh;
               done = 1'b1;
               next_s.hostState = SPIHC_IDLE;
               next_s.step = 5'h00;
            end
         end
      end else if (clientMode) begin
         next_s.sckOe = 1'b0;
         next_s.sckLvl = s.cpol;
         next_s.hostState = SPIHC_IDLE;
         ssActive = ssCtl ? !s.ssS2 : 1'b1;
         next_s.sdoOe = ssActive;
         if (!ssActive) begin
            next_s.bitCnt = 4'h0;
         end else if (s.sckS2 != s.sckPrev) begin
            // Runs off ref_clk, which keeps going while the core sleeps
            leading = s.sckS2 != s.cpol;
            sampleEdge = s.cke ? leading : !leading;
            changeEdge = !sampleEdge;
            if (sampleEdge) begin
               sh = {s.shreg[6:0], s.sdiS2};
               next_s.shreg = sh;
               if (s.bitCnt == `SPIHC_LAST_BIT) begin
                  next_s.bitCnt = 4'h0;
                  done = 1'b1;
               end else begin
                  next_s.bitCnt = s.bitCnt + 4'h1;
               end
            end
            if (changeEdge) begin
               next_s.outBit = s.shreg[7];
            end
         end
      end else begin
         next_s.sckOe = 1'b0;
         next_s.sdoOe = 1'b0;
         next_s.sckLvl = s.cpol;
         next_s.hostState = SPIHC_IDLE;
      end

      // Completion set wins over a same-cycle read clear, except when bf was already set and overwrite is off
      if (done) begin
         if (!s.bf || s.buffer_overwrite_enable) begin
            next_s.dataBuf = sh;
            next_s.bf = 1'b1;
         end else begin
            next_s.ovf = 1'b1;
         end
         next_s.intFlag = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
         s.hostState <= SPIHC_IDLE;
         s.mode <= `SPIHC_RST_MODE;
         s.enable <= `SPIHC_RST_CTRL;
         s.dataBuf <= `SPIHC_RST_BYTE;
         s.reload <= `SPIHC_RST_BYTE;
      end else begin
         s <= next_s;
      end
   end

   assign regRdata = s.rdData;
   assign sckOut = s.sckLvl;
   assign sckOe = s.sckOe;
   assign sdoOut = s.outBit;
   assign sdoOe = s.sdoOe;
   assign portInterruptFlag = s.intFlag;
   assign bufferFullFlag = s.bf;

endmodule

// *** bench/spihc_port_asserts.sv ***
// Checker for the SPI host/client port, watching its pins only.
// Assumes it is bound to spihc_port by the statement at the foot.
`timescale 1ns/10ps
module spihc_port_asserts (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [2:0] regAddr,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdata,
   input wire logic sleepReq,
   input wire logic sckOut,
   input wire logic sckOe,
   input wire logic sdoOe,
   input wire logic ssIn_b,
   input wire logic portInterruptFlag,
   input wire logic bufferFullFlag
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   logic sckPrev;
   logic oePrev;
   logic [5:0] togCnt;
   // Clock edges of one host byte; the enable edge itself is not counted
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sckPrev <= 1'b0;
         oePrev <= 1'b0;
         togCnt <= 6'h00;
      end else begin
         sckPrev <= sckOut;
         oePrev <= sckOe;
         if (!sckOe || portInterruptFlag)
            togCnt <= 6'h00;
         else if (oePrev && sckOut != sckPrev)
            togCnt <= togCnt + 6'h01;
      end
   end
   sequence hostWr;
      sckOe && regWr && regAddr == 3'h3;
   endsequence
   sequence selLow;
      (!sckOe && !ssIn_b) [*6];
   endsequence
   start_clk_a: assert property (hostWr |-> ##[1:70] $changed(sckOut))
      else $error("host clock did not start");
   tog_count_a: assert property (
      $rose(portInterruptFlag) && sckOe |-> togCnt == 6'h10)
      else $error("host byte not sixteen clock edges");
   bf_flag_a: assert property ($rose(bufferFullFlag) |-> portInterruptFlag)
      else $error("buffer full without flag");
   rd_clear_a: assert property (
      regRd && regAddr == 3'h3 |=> !bufferFullFlag)
      else $error("buffer read left full set");
   no_addr_a: assert property (
      regRd && regAddr > 3'h5 |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   sleep_hold_a: assert property (sckOe && sleepReq |=> $stable(sckOut))
      else $error("host clock moved in sleep");
   sel_drive_a: assert property (selLow |-> sdoOe)
      else $error("selected client not driving");
   sel_release_a: assert property (
      $rose(ssIn_b) && !sckOe |-> ##[1:4] !sdoOe)
      else $error("deselected client still driving");
endmodule
bind spihc_port spihc_port_asserts u_asserts (.ref_clk, .rst_b, .regAddr,
   .regWr, .regRd, .regRdata, .sleepReq, .sckOut, .sckOe, .sdoOe, .ssIn_b,
   .portInterruptFlag, .bufferFullFlag);

// *** bench/spihc_partner.sv ***
// Serial client model facing the port while it is host.
// Assumes clock edge set: samples on leading edge, shifts on trailing.
`timescale 1ns/10ps
module spihc_partner (
   input wire logic ref_clk,
   input wire logic sck,
   input wire logic cpol,
   input wire logic mosi,
   input wire logic active,
   input wire logic load,
   input wire logic [7:0] txByte,
   output logic miso,
   output logic [7:0] rxByte
);
   logic [7:0] sh = 8'h00;
   initial rxByte = 8'h00;
   // Released line shows the inverse so a stale bit never reads as good
   assign miso = active ? sh[7] : ~sh[7];
   always @(posedge ref_clk)
      if (load)
         sh <= txByte;
   always @(sck)
      if (active && sck != cpol)
         rxByte <= {rxByte[6:0], mosi};
      else if (active)
         sh <= {sh[6:0], 1'b0};
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the SPI host/client port.
// Assumes the checker binds itself and the partner answers as client.
`timescale 1ns/10ps
module tb;
   logic ref_clk = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWdata = 8'h00, tx = 8'h00, px = 8'h00, got = 8'h00;
   logic sleepReq = 1'b0, periodMatch = 1'b0, ssIn_b = 1'b1;
   logic cliSck = 1'b0, cliSdi = 1'b0, load = 1'b0, cpol = 1'b0;
   logic rdPend = 1'b0;
   logic [7:0] regRdata, rxByte;
   logic sckOut, sckOe, sdoOut, sdoOe, miso, sckIn, sdiIn;
   logic portInterruptFlag, bufferFullFlag;
   logic [3:0] modes [5] = '{4'h0, 4'h1, 4'h2, 4'hA, 4'h3};
   logic [7:0] expQ [$];
   int errCount = 0;
   int nCompared = 0;
   assign sckIn = sckOe ? sckOut : cliSck;
   assign sdiIn = sckOe ? miso : cliSdi;
   spihc_port dut (.ref_clk, .rst_b, .regAddr, .regWdata, .regWr, .regRd,
      .regRdata, .sleepReq, .periodMatch, .sckIn, .sckOut, .sckOe, .sdiIn,
      .sdoOut, .sdoOe, .ssIn_b, .portInterruptFlag, .bufferFullFlag);
   spihc_partner peer (.ref_clk, .sck(sckOut), .cpol, .mosi(sdoOut),
      .active(sckOe), .load, .txByte(px), .miso, .rxByte);
   initial forever #2 ref_clk = ~ref_clk;
   // Matches never come back to back, so a half period is two cycles or more
   always @(posedge ref_clk)
      periodMatch <= (($urandom % 5) == 0) && !periodMatch;
   task automatic check(input logic [7:0] g, input logic [7:0] e);
      nCompared++;
      if (g !== e) begin
         errCount++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   always @(posedge ref_clk) begin
      rdPend <= regRd;
      if (rdPend)
         check(regRdata, expQ.pop_front());
   end
   // One idle cycle after each strobe keeps every driver single per step
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      regWr <= w;
      regRd <= !w;
      regAddr <= a;
      regWdata <= d;
      @(posedge ref_clk);
      regWr <= 1'b0;
      regRd <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      expQ.push_back(e);
      acc(1'b0, a, 8'h00);
   endtask
   task automatic waitFlag();
      for (int i = 0; i < 3000 && portInterruptFlag !== 1'b1; i++)
         @(posedge ref_clk);
   endtask
   // Client frame, clock edge clear: change on rise, port samples on fall
   task automatic cli(input logic [7:0] b, input int n);
      ssIn_b <= 1'b0;
      repeat (8) @(posedge ref_clk);
      for (int i = 7; i > 7 - n; i--) begin
         cliSck <= 1'b1;
         cliSdi <= b[i];
         repeat (8) @(posedge ref_clk);
         got = {got[6:0], sdoOut};
         cliSck <= 1'b0;
         repeat (8) @(posedge ref_clk);
      end
      ssIn_b <= 1'b1;
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic summarize();
      $display("compared %0d, mismatches %0d", nCompared, errCount);
      if (errCount == 0 && nCompared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge ref_clk);
      errCount++;
      summarize();
   end
   initial begin
      void'($urandom(18905));
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      rd(3'h1, 8'h00);
      rd(3'h6, 8'h00);
      acc(1'b1, 3'h0, 8'h40);
      for (int i = 0; i < 5; i++) begin
         cpol <= i[0];
         acc(1'b1, 3'h1, {3'b000, i[0], modes[i]});
         acc(1'b1, 3'h4, 8'h03);
         acc(1'b1, 3'h1, {3'b001, i[0], modes[i]});
         tx = $urandom;
         px = $urandom;
         load <= 1'b1;
         @(posedge ref_clk);
         load <= 1'b0;
         acc(1'b1, 3'h3, tx);
         acc(1'b1, 3'h3, ~tx);
         sleepReq <= 1'b1;
         repeat (20) @(posedge ref_clk);
         sleepReq <= 1'b0;
         waitFlag();
         rd(3'h0, 8'h41);
         rd(3'h3, px);
         rd(3'h0, 8'h40);
         rd(3'h1, {3'b101, i[0], modes[i]});
         check(rxByte, tx);
         acc(1'b1, 3'h5, 8'h00);
      end
      acc(1'b1, 3'h1, 8'h04);
      acc(1'b1, 3'h0, 8'h00);
      rd(3'h0, 8'h00);
      acc(1'b1, 3'h1, 8'h24);
      cli(8'hFF, 3);
      tx = $urandom;
      px = $urandom;
      acc(1'b1, 3'h3, tx);
      sleepReq <= 1'b1;
      cli(px, 8);
      sleepReq <= 1'b0;
      check(got, tx);
      waitFlag();
      rd(3'h3, px);
      rd(3'h5, 8'h01);
      acc(1'b1, 3'h5, 8'h00);
      acc(1'b1, 3'h2, 8'h10);
      cli(8'h5A, 8);
      cli(~px, 8);
      rd(3'h3, ~px);
      summarize();
   end
endmodule
